// >>> eew_master.sv
// bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module eew_master (
  input wire logic link_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q;
    repeat (8) @(posedge link_clk);
  endtask : q
  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_low = ~b; // released level comes from the pull-up
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
  endtask : bit_io
  // data falls while clock high, also as repeated start
  task automatic start;
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask : start
  // data rises while clock high
  task automatic stop;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop
  // msb first, ninth bit left released for the answer
  task automatic tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : tx
  task automatic rx(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~more, r);
  endtask : rx
endmodule : eew_master

// >>> eew_mem.sv
// small memory with lane write enables and registered read data
`timescale 1ns/1ps
module eew_mem #(
  parameter int DW = 32,
  parameter int AW = 4,
  parameter int LANES = 1,
  parameter logic [DW-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [LANES-1:0] wr_lane,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  localparam int LW = DW / LANES;

  // contents set to INIT at power-up (check-bit encoded erased word for the array, zero for the page buffer)
  logic [DW-1:0] mem_q [0:(1<<AW)-1] = '{default: INIT};

  always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_en && wr_lane[l]) mem_q[wr_addr][l*LW +: LW] <= wr_data[l*LW +: LW];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : eew_mem

// >>> eew_pkg.sv
// shared constants, types and check-bit functions for the serial eeprom write slave
package eew_pkg;

  localparam int ADDR_W_DEF = 14;
  localparam int PAGE_BYTES_DEF = 64;
  // arbitrary neutral device type value
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_STRAP_LSB = 1;
  localparam int SEL_RW_BIT = 0;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  localparam int CLK_MHZ = 50;
  localparam int INTERNAL_PROGRAM_TIME_US = 5;
  localparam int PROG_CYCLES_DEF = INTERNAL_PROGRAM_TIME_US * CLK_MHZ;

  localparam int DATA_W = 32;
  localparam int CHK_W = 6;
  localparam int CODE_W = DATA_W + CHK_W;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_DEVSEL   = 4'h1,
    ST_ADDR_HI  = 4'h2,
    ST_ADDR_LO  = 4'h3,
    ST_WDATA    = 4'h4,
    ST_RFETCH   = 4'h5,
    ST_RLOAD    = 4'h6,
    ST_RDATA    = 4'h7,
    ST_PRG_RD   = 4'h8,
    ST_PRG_WR   = 4'h9,
    ST_PRG_WAIT = 4'ha
  } eew_state_type;

  // hamming code, check bits at power-of-two positions
  function automatic logic [CODE_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0] c;
    logic par;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int i = 0; i < CHK_W; i++) begin
      par = 1'b0;
      for (int p = 1; p <= CODE_W; p++) begin
        if (((p >> i) & 1) != 0) par = par ^ c[p-1];
      end
      c[(1 << i) - 1] = par;
    end
    return c;
  endfunction : ecc_encode

  function automatic logic [DATA_W-1:0] ecc_decode(input logic [CODE_W-1:0] c);
    logic [CODE_W-1:0] f;
    logic [CHK_W-1:0] s;
    logic [DATA_W-1:0] d;
    int k;
    s = '0;
    d = '0;
    k = 0;
    for (int i = 0; i < CHK_W; i++) begin
      for (int p = 1; p <= CODE_W; p++) begin
        if (((p >> i) & 1) != 0) s[i] = s[i] ^ c[p-1];
      end
    end
    f = c;
    if (s != '0 && int'(s) <= CODE_W) f[int'(s) - 1] = ~f[int'(s) - 1];
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = f[p-1];
        k++;
      end
    end
    return d;
  endfunction : ecc_decode

endpackage : eew_pkg

// >>> eew_slave.sv
// serial two-wire eeprom slave: select, addressing, byte and page write, reads
`timescale 1ns/1ps
module eew_slave #(
  parameter int ADDR_W = eew_pkg::ADDR_W_DEF,
  parameter int PAGE_BYTES = eew_pkg::PAGE_BYTES_DEF,
  parameter logic [3:0] DEV_TYPE = eew_pkg::DEV_TYPE_DEF,
  parameter bit ECC_EN = 1'b0,
  parameter int PROG_CYCLES = eew_pkg::PROG_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  input wire logic write_protect_input
);
  import eew_pkg::*;

  localparam int OFF_W = $clog2(PAGE_BYTES);
  localparam int WRD_W = OFF_W - 2;
  localparam int ROW_W = ADDR_W - OFF_W;
  localparam logic [WRD_W-1:0] LAST_WORD = WRD_W'(PAGE_BYTES / 4 - 1);

  eew_state_type state_q;
  logic [7:0] link_shift_q;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic scl_d_q;
  logic sda_d_q;
  logic [3:0] bit_cnt_q;
  logic ack_pend_q;
  logic rw_q;
  logic wp_seen_q;
  logic data_acked_q;
  logic [7:0] addr_hi_q;
  logic [ADDR_W-1:0] addr_q;
  logic [PAGE_BYTES-1:0] mask_q;
  logic [WRD_W-1:0] word_q;
  logic [7:0] tx_q;
  logic [31:0] prog_cnt_q;
  logic [CODE_W-1:0] arr_rdata;
  logic [31:0] buf_rdata;
  logic [31:0] dec_word;
  logic [31:0] merged;
  logic [3:0] word_mask;

  wire scl_s = sync2_q[0];
  wire sda_s = sync2_q[1];
  wire wp_s = sync2_q[2];
  wire [2:0] strap_s = sync2_q[5:3];
  wire rise_ev = scl_s & ~scl_d_q;
  wire fall_ev = ~scl_s & scl_d_q;
  wire start_ev = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_ev = scl_s & scl_d_q & ~sda_d_q & sda_s;
  wire byte_done = rise_ev && bit_cnt_q == LAST_DATA_BIT;
  wire ack_rise = rise_ev && bit_cnt_q == ACK_BIT;
  wire in_prog = state_q == ST_PRG_RD || state_q == ST_PRG_WR || state_q == ST_PRG_WAIT;
  wire sel_match = link_shift_q[7:SEL_TYPE_LSB] == DEV_TYPE
                   && link_shift_q[SEL_RW_BIT+3:SEL_STRAP_LSB] == strap_s;
  wire [ROW_W-1:0] addr_row = addr_q[ADDR_W-1:OFF_W];
  wire [OFF_W-1:0] addr_off = addr_q[OFF_W-1:0];
  // the clock rise of a stop right after a data ack is the tenth bit slot
  wire prog_go = state_q == ST_WDATA && bit_cnt_q == 4'h1 && data_acked_q && !wp_seen_q;
  wire buf_we = state_q == ST_WDATA && byte_done && !wp_seen_q;
  wire [ADDR_W-3:0] arr_raddr = in_prog ? {addr_row, word_q} : addr_q[ADDR_W-1:2];
  wire arr_we = state_q == ST_PRG_WR && word_mask != 4'h0;

  // link side: shift in the data line on the serial clock
  always_ff @(posedge scl or negedge reset_n) begin
    if (!reset_n) begin
      link_shift_q <= 8'h00;
    end else begin
      link_shift_q <= {link_shift_q[6:0], sda_in};
    end
  end

  // pin synchronisers; the shift register is read only after a synced rising edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 6'h03;
      sync2_q <= 6'h03;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      sync1_q <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0,
                  write_protect_input, sda_in, scl};
      sync2_q <= sync1_q;
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  always_comb begin
    dec_word = ECC_EN ? ecc_decode(arr_rdata) : arr_rdata[31:0];
    for (int l = 0; l < 4; l++) begin
      word_mask[l] = mask_q[{word_q, 2'(l)}];
      merged[l*8 +: 8] = word_mask[l] ? buf_rdata[l*8 +: 8] : dec_word[l*8 +: 8];
    end
  end

  // protocol state machine
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      ack_pend_q <= 1'b0;
      rw_q <= 1'b0;
      wp_seen_q <= 1'b0;
      data_acked_q <= 1'b0;
      addr_hi_q <= 8'h00;
      addr_q <= '0;
      mask_q <= '0;
      word_q <= '0;
      tx_q <= 8'h00;
    end else if (in_prog) begin
      case (state_q)
        ST_PRG_RD: state_q <= ST_PRG_WR;
        ST_PRG_WR: begin
          word_q <= WRD_W'(word_q + 1'b1);
          state_q <= (word_q == LAST_WORD) ? ST_PRG_WAIT : ST_PRG_RD;
        end
        default: begin
          if (prog_cnt_q >= 32'(PROG_CYCLES - 1)) state_q <= ST_IDLE;
        end
      endcase
    end else if (start_ev) begin
      state_q <= ST_DEVSEL;
      bit_cnt_q <= 4'h0;
      ack_pend_q <= 1'b0;
      wp_seen_q <= wp_s;
      data_acked_q <= 1'b0;
      mask_q <= '0;
    end else if (stop_ev) begin
      word_q <= '0;
      state_q <= prog_go ? ST_PRG_RD : ST_IDLE;
    end else begin
      if ((state_q == ST_DEVSEL || state_q == ST_ADDR_HI || state_q == ST_ADDR_LO) && wp_s) begin
        wp_seen_q <= 1'b1;
      end
      if (rise_ev && state_q != ST_IDLE) begin
        bit_cnt_q <= (bit_cnt_q == ACK_BIT) ? 4'h0 : 4'(bit_cnt_q + 1'b1);
      end
      if (rise_ev && bit_cnt_q == 4'h1) data_acked_q <= 1'b0;
      case (state_q)
        ST_DEVSEL: begin
          if (byte_done) begin
            if (sel_match) begin
              ack_pend_q <= 1'b1;
              rw_q <= link_shift_q[SEL_RW_BIT];
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (ack_rise) begin
            state_q <= rw_q ? ST_RFETCH : ST_ADDR_HI;
          end
        end
        ST_ADDR_HI: begin
          if (byte_done) begin
            addr_hi_q <= link_shift_q;
            ack_pend_q <= 1'b1;
          end else if (ack_rise) begin
            state_q <= ST_ADDR_LO;
          end
        end
        ST_ADDR_LO: begin
          if (byte_done) begin
            addr_q <= ADDR_W'({addr_hi_q, link_shift_q});
            ack_pend_q <= 1'b1;
          end else if (ack_rise) begin
            state_q <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            ack_pend_q <= !wp_seen_q;
            if (!wp_seen_q) mask_q[addr_off] <= 1'b1;
          end else if (ack_rise) begin
            data_acked_q <= ack_pend_q;
            if (ack_pend_q) addr_q <= {addr_row, OFF_W'(addr_off + 1'b1)};
          end
        end
        ST_RFETCH: state_q <= ST_RLOAD;
        ST_RLOAD: begin
          tx_q <= dec_word[addr_q[1:0]*8 +: 8];
          state_q <= ST_RDATA;
        end
        ST_RDATA: begin
          if (ack_rise) begin
            addr_q <= ADDR_W'(addr_q + 1'b1);
            state_q <= sda_s ? ST_IDLE : ST_RFETCH;
          end
        end
        default: ;
      endcase
    end
  end

  // programming time counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_cnt_q <= 32'h0;
    end else if (in_prog) begin
      prog_cnt_q <= prog_cnt_q + 32'h1;
    end else begin
      prog_cnt_q <= 32'h0;
    end
  end

  // data line driver, set after a falling clock edge, released at once on start, stop, idle or programming
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_oe <= 1'b0;
    end else if (in_prog || state_q == ST_IDLE || start_ev || stop_ev) begin
      sda_oe <= 1'b0;
    end else if (fall_ev) begin
      if (state_q == ST_RDATA && bit_cnt_q < ACK_BIT) begin
        sda_oe <= ~tx_q[3'(LAST_DATA_BIT - bit_cnt_q)];
      end else if (bit_cnt_q == ACK_BIT) begin
        sda_oe <= ack_pend_q && state_q != ST_RDATA;
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0;

  eew_mem #(
    .DW(CODE_W),
    .AW(ADDR_W - 2),
    .LANES(1),
    .INIT(ecc_encode(ERASED_WORD))
  ) u_array (
    .clk(core_clk),
    .reset_n(reset_n),
    .wr_en(arr_we),
    .wr_lane(1'b1),
    .wr_addr({addr_row, word_q}),
    .wr_data(ECC_EN ? ecc_encode(merged) : {CHK_W'(0), merged}),
    .rd_addr(arr_raddr),
    .rd_data(arr_rdata)
  );

  eew_mem #(
    .DW(32),
    .AW(WRD_W),
    .LANES(4),
    .INIT(32'h0)
  ) u_page (
    .clk(core_clk),
    .reset_n(reset_n),
    .wr_en(buf_we),
    .wr_lane(4'(4'h1 << addr_q[1:0])),
    .wr_addr(addr_off[OFF_W-1:2]),
    .wr_data({4{link_shift_q}}),
    .rd_addr(word_q),
    .rd_data(buf_rdata)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  prog_no_drive_a: assert property (in_prog |-> !sda_oe)
    else $error("data line driven while programming");
  out_low_only_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  sel_mismatch_a: assert property (state_q == ST_DEVSEL && byte_done && !sel_match && !start_ev
    && !stop_ev |=> state_q == ST_IDLE ##1 !sda_oe)
    else $error("mismatched select not released");
  sel_match_ack_a: assert property (state_q == ST_DEVSEL && byte_done && sel_match && !start_ev
    && !stop_ev |=> ack_pend_q)
    else $error("matching select not acknowledged");
  wp_nack_a: assert property (state_q == ST_WDATA && byte_done && wp_seen_q && !start_ev
    && !stop_ev |=> !ack_pend_q && mask_q == $past(mask_q))
    else $error("protected data byte accepted");
  stop_prog_a: assert property (stop_ev && !in_prog && prog_go |=> state_q == ST_PRG_RD)
    else $error("programming not started on stop");
  stop_standby_a: assert property (stop_ev && !in_prog && !prog_go |=> state_q == ST_IDLE)
    else $error("stop did not return to standby");
  start_ignored_a: assert property (start_ev && in_prog
    && prog_cnt_q < 32'(PROG_CYCLES - 1) |=> in_prog)
    else $error("start accepted while programming");
  inrow_step_a: assert property (state_q == ST_WDATA && ack_rise && ack_pend_q && !start_ev
    && !stop_ev |=> addr_row == $past(addr_row)
    && addr_off == OFF_W'($past(addr_off) + 1'b1))
    else $error("page counter left its row");
  addr_seq_a: assert property (state_q == ST_DEVSEL && ack_rise && !rw_q && !start_ev
    && !stop_ev |=> state_q == ST_ADDR_HI)
    else $error("address bytes not expected after write select");
  prog_hold_a: assert property (state_q == ST_PRG_WAIT && prog_cnt_q < 32'(PROG_CYCLES - 1)
    |=> state_q == ST_PRG_WAIT && addr_q == $past(addr_q))
    else $error("programming ended early");

  prog_run_c: cover property (state_q == ST_PRG_WAIT ##1 state_q == ST_IDLE);
  read_byte_c: cover property (state_q == ST_RLOAD ##1 state_q == ST_RDATA);
  wp_block_c: cover property (state_q == ST_WDATA && byte_done && wp_seen_q);
  mismatch_c: cover property (state_q == ST_DEVSEL && byte_done && !sel_match);

endmodule : eew_slave

// >>> testbench.sv
// self-checking bench for the serial eeprom write slave
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import eew_pkg::*;
  localparam int PB = 8;
  localparam int AW = 14;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic wp = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic sda;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 8109;
  logic [7:0] mem [2**AW];
  logic [AW-1:0] cnt;
  logic ack;
  logic [7:0] d;
  logic [15:0] a;
  // open-drain wire with pull-up
  assign sda = ~sda_low & ~(sda_oe & ~sda_out);
  always #10 core_clk = ~core_clk;
  always #6 link_clk = ~link_clk;
  eew_slave #(.ADDR_W(AW), .PAGE_BYTES(PB), .ECC_EN(1'b1), .PROG_CYCLES(400)) eew_slave_inst (
    .core_clk(core_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .write_protect_input(wp));
  eew_master eew_master_inst (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  function automatic logic [7:0] sel(input logic rw);
    return {DEV_TYPE_DEF, strap, rw};
  endfunction : sel
  function automatic logic [AW-1:0] in_row(input logic [AW-1:0] b, input int i);
    return AW'((b / PB) * PB + (b % PB + i) % PB);
  endfunction : in_row
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic tx(input logic [7:0] b, input logic ea);
    eew_master_inst.tx(b, ack);
    `CHK(ack, ea)
  endtask : tx
  task automatic hdr;
    eew_master_inst.start();
    tx(sel(1'b0), 1'b1);
    tx(a[15:8], 1'b1);
    tx(a[7:0], 1'b1);
  endtask : hdr
  // poll with selects; the first must go unanswered while busy
  task automatic wait_rdy;
    for (int k = 0; k < 30; k++) begin
      eew_master_inst.start();
      eew_master_inst.tx(sel(1'b0), ack);
      eew_master_inst.stop();
      if (k == 0) `CHK(ack, 1'b0)
      if (ack) return;
    end
    error_cnt++;
    close_out();
  endtask : wait_rdy
  task automatic wr(input int n, input logic wpv);
    hdr();
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      tx(d, ~wpv);
      if (!wpv) mem[in_row(a[AW-1:0], i)] = d;
    end
    eew_master_inst.stop();
    if (!wpv) begin
      cnt = in_row(a[AW-1:0], n);
      wait_rdy();
    end
  endtask : wr
  task automatic rd(input int n, input logic rnd);
    if (rnd) begin
      hdr();
      cnt = a[AW-1:0];
    end
    eew_master_inst.start();
    tx(sel(1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      eew_master_inst.rx(i < n - 1, d);
      `CHK(d, mem[cnt])
      cnt++;
    end
    eew_master_inst.stop();
  endtask : rd
  initial begin
    #1500000;
    error_cnt++;
    close_out();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    cnt = '0;
    a = '0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    @(negedge core_clk) strap = $random(seed);
    repeat (10) @(negedge core_clk);
    // every strap code plus a wrong type field
    for (int s = 0; s < 9; s++) begin
      eew_master_inst.start();
      d = (s == 8) ? {~DEV_TYPE_DEF, strap, 1'b0} : {DEV_TYPE_DEF, 3'(s), 1'b0};
      eew_master_inst.tx(d, ack);
      `CHK(ack, (s < 8 && 3'(s) == strap))
      eew_master_inst.stop();
    end
    $display("test select done");
    repeat (3) begin
      a = $random(seed);
      wr(1, 1'b0);
      rd(1, 1'b0);
      rd(1, 1'b1);
    end
    $display("test byte write done");
    @(negedge core_clk) wp = 1'b1;
    wr(2, 1'b1);
    rd(2, 1'b1);
    rd(1, 1'b0);
    @(negedge core_clk) wp = 1'b0;
    $display("test protect done");
    a = ($random(seed) & 16'hfff8) | 16'h0006;
    wr(PB + 2, 1'b0);
    rd(1, 1'b0);
    a = a & 16'hfff8;
    rd(PB, 1'b1);
    $display("test page wrap done");
    a = $random(seed) & 16'hfffc;
    wr(4, 1'b0);
    rd(4, 1'b1);
    $display("test aligned word done");
    hdr();
    eew_master_inst.stop();
    hdr();
    d = $random(seed);
    tx(d, 1'b1);
    repeat (4) eew_master_inst.bit_io(1'b0, ack);
    eew_master_inst.stop();
    rd(2, 1'b1);
    $display("test stop slot done");
    close_out();
  end
endmodule : testbench
